// ### sac_afe_model.sv
// analog side model: sample-and-hold of the chosen input and comparator
`timescale 1ns/1ns
module sac_afe_model (
  input wire logic clk_sys,
  input wire logic [11:0][9:0] level,
  input wire logic [3:0] analog_chan_sel,
  input wire logic sample_hold,
  input wire logic [9:0] dac_code,
  output logic comp_above
);
  logic [9:0] held_q;
  // level is frozen once sampling ends, as a real hold capacitor would be
  always_ff @(posedge clk_sys) begin
    if (sample_hold) begin
      held_q <= level[analog_chan_sel];
    end
  end
  assign comp_above = held_q >= dac_code;
endmodule // sac_afe_model

// ### sac_core.sv
// converter control core: sequencing, successive approximation, registers
// How it works
// [R01] ten result bits sit in bits 15 down to 6 of each result register
// [R02] the six low result bits always read as zero
// [R03] upper-byte read returns it and latches the low byte into a holding register
// [R04] software reads upper byte first, or whole word; lone low read unreliable
// [R05] group inputs one to four land in result registers a to d; group 3 prohibited
// [R06] twelve inputs form groups 0-3, 4-7 and 8-11
// [R07] single mode converts one channel; scan mode cycles one to four channels
// [R08] each channel takes 13.3 us worth of 20 MHz clocks
// [R09] start comes from software, the timer trigger or the external pin
// [R10] end flag bit 7 sets after single channel or after a full scan pass
// [R11] software clears the end flag only by writing zero after reading it as one
// [R12] a transfer-controller read of a result register clears the end flag
// [R13] interrupt enable bit 6 lets the end interrupt out
// [R14] module stop halts the converter
// [R15] start bit 5: clear stops, set starts; single self-clears, scan runs on
// [R16] interrupt is high while end flag and enable are both set
`timescale 1ns/1ns
module sac_core
  import sac_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire sac_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  input wire logic conv_module_stop_bit,
  input wire logic timer_pulse_unit_trig,
  input wire logic ext_conv_trigger,
  input wire logic comp_above,
  output logic [3:0] analog_chan_sel,
  output logic sample_hold,
  output logic [9:0] dac_code,
  output logic conv_end_irq
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  sac_csr_t csr_q;
  sac_csr_t csr_d;
  logic [7:0] ctrl_q;
  logic [9:0] res_q [4];
  logic [7:0] temp_q;
  logic [7:0] rdata_q;
  logic armed_q;
  logic armed_d;
  logic ext_prev_q;
  sac_state_t st_q;
  sac_state_t st_d;
  logic [8:0] tmr_q;
  logic [1:0] slot_q;
  logic [9:0] dac_q;
  logic [9:0] mask_q;
  logic [3:0] chan_sel_q;
  logic hold_q;

  // ------------------------------------------------------------
  // register bus decode
  // ------------------------------------------------------------
  // while stopped the registers hold, except the start bit, which clears: no reads answer, no writes land
  wire live = ~conv_module_stop_bit;
  wire rd = bus_req.rd & live;
  wire wr = bus_req.wr & live;
  wire is_res = bus_req.idx <= SAC_IDX_RES_D_LO;
  wire is_hi = is_res & ~bus_req.idx[0];
  wire [1:0] res_sel = bus_req.idx[2:1];
  wire csr_rd = rd & (bus_req.idx == SAC_IDX_CSR);
  wire csr_wr = wr & (bus_req.idx == SAC_IDX_CSR);
  wire ctrl_wr = wr & (bus_req.idx == SAC_IDX_CTRL);
  wire [7:0] wd = bus_req.wdata;

  // result bytes: ten bits left-justified, six low bits forced to zero
  wire [15:0] res_word = {res_q[res_sel], SAC_RES_PAD}; // [R01] [R02]
  wire [7:0] res_hi = res_word[15:8];
  wire [7:0] res_lo = res_word[7:0];

  // read data mux; the low byte always comes from the holding register
  wire [7:0] rd_mux = is_hi ? res_hi : // [R03]
                      is_res ? temp_q : // [R04]
                      (bus_req.idx == SAC_IDX_CSR) ? csr_q :
                      (bus_req.idx == SAC_IDX_CTRL) ? ctrl_q : 8'h00;

  // ------------------------------------------------------------
  // start sources
  // ------------------------------------------------------------
  // the external pin starts on its falling edge
  wire ext_fall = ext_prev_q & ~ext_conv_trigger;
  wire trig_hw = (ctrl_q[SAC_CTRL_TMR_EN_BIT] & timer_pulse_unit_trig) | // [R09]
                 (ctrl_q[SAC_CTRL_EXT_EN_BIT] & ext_fall); // [R09]

  // ------------------------------------------------------------
  // sequencer conditions
  // ------------------------------------------------------------
  wire bad_group = csr_q.group == SAC_GROUP_BAD; // [R05]
  wire go = csr_q.start & live & ~bad_group;
  wire sample_end = (st_q == SAC_ST_SAMPLE) & (tmr_q == 9'(SAC_SAMPLE_CYC - 1));
  wire bit_end = (st_q == SAC_ST_BITS) & (tmr_q == 9'(SAC_BIT_CYC - 1));
  // comparator decides the trial bit under test
  wire [9:0] kept = comp_above ? dac_q : (dac_q & ~mask_q);
  wire chan_done = bit_end & mask_q[0] & go; // [R08]
  wire last_slot = ~csr_q.scan | (slot_q == csr_q.chan); // [R07]
  wire pass_done = chan_done & last_slot; // [R10]
  // slot of the next conversion: first slot in scan, the chosen one in single
  wire [1:0] first_slot = csr_q.scan ? 2'h0 : csr_q.chan; // [R07]
  wire [1:0] next_slot = last_slot ? first_slot : 2'(slot_q + 2'h1);

  // ------------------------------------------------------------
  // end flag and its two clearing paths
  // ------------------------------------------------------------
  wire clr_sw = csr_wr & ~wd[SAC_CSR_FLAG_BIT] & armed_q; // [R11]
  wire clr_xfer = rd & bus_req.xfer & is_res; // [R12]
  wire flag_clr = clr_sw | clr_xfer;
  // a new end beats a clear arriving in the same cycle
  wire flag_next = pass_done | (csr_q.flag & ~flag_clr); // [R10]
  assign armed_d = flag_clr ? 1'b0 : (armed_q | (csr_rd & csr_q.flag)); // [R11]

  // ------------------------------------------------------------
  // control/status next value
  // ------------------------------------------------------------
  always_comb begin
    csr_d = csr_q;
    csr_d.flag = flag_next;
    if (csr_wr) begin
      csr_d.irq_en = wd[SAC_CSR_IE_BIT]; // [R13]
      csr_d.scan = wd[SAC_CSR_SCAN_BIT];
      csr_d.group = wd[3:2]; // [R06]
      csr_d.chan = wd[1:0];
    end
    // start bit: stop wins, then writes, then hardware clears, then triggers
    if (conv_module_stop_bit) begin
      csr_d.start = 1'b0; // [R14]
    end else if (csr_wr) begin
      csr_d.start = wd[SAC_CSR_START_BIT]; // [R15]
    end else if (csr_q.start & (bad_group | (pass_done & ~csr_q.scan))) begin
      csr_d.start = 1'b0; // [R15]
    end else if (trig_hw) begin
      csr_d.start = 1'b1; // [R09]
    end
  end

  // ------------------------------------------------------------
  // sequencer next state
  // ------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      SAC_ST_IDLE: begin
        if (go) begin
          st_d = SAC_ST_SAMPLE;
        end
      end
      SAC_ST_SAMPLE: begin
        if (!go) begin
          st_d = SAC_ST_IDLE; // [R15]
        end else if (sample_end) begin
          st_d = SAC_ST_BITS;
        end
      end
      SAC_ST_BITS: begin
        if (!go) begin
          st_d = SAC_ST_IDLE; // [R14]
        end else if (chan_done) begin
          st_d = (last_slot & ~csr_q.scan) ? SAC_ST_IDLE : SAC_ST_SAMPLE; // [R07]
        end
      end
    endcase
  end

  // ------------------------------------------------------------
  // register file flops
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      csr_q <= SAC_CSR_RESET;
      ctrl_q <= SAC_CTRL_RESET;
      armed_q <= 1'b0;
    end else begin
      csr_q <= csr_d;
      armed_q <= armed_d;
      if (ctrl_wr) begin
        ctrl_q <= wd;
      end
    end
  end

  // read data and the low-byte holding register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 8'h00;
      temp_q <= 8'h00;
    end else if (rd) begin
      rdata_q <= rd_mux;
      if (is_hi) begin
        temp_q <= res_lo; // [R03]
      end
    end
  end

  // trigger pin history
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ext_prev_q <= 1'b1;
    end else begin
      ext_prev_q <= ext_conv_trigger;
    end
  end

  // ------------------------------------------------------------
  // sequencer flops
  // ------------------------------------------------------------
  // the timer restarts at every phase change, so aborts leave no residue
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= SAC_ST_IDLE;
      tmr_q <= 9'h000;
      slot_q <= 2'h0;
    end else begin
      st_q <= st_d;
      if ((st_d != st_q) | sample_end | bit_end) begin
        tmr_q <= 9'h000;
      end else begin
        tmr_q <= 9'(tmr_q + 9'h001);
      end
      if (st_q == SAC_ST_IDLE) begin
        slot_q <= first_slot;
      end else if (chan_done) begin
        slot_q <= next_slot;
      end
    end
  end

  // successive approximation: try each bit from the top down
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dac_q <= 10'h000;
      mask_q <= 10'h000;
    end else if (sample_end) begin
      dac_q <= 10'h200;
      mask_q <= 10'h200;
    end else if (bit_end) begin
      dac_q <= kept | (mask_q >> 1);
      mask_q <= mask_q >> 1;
    end
  end

  // results; not reset, as the registers hold whatever was last converted
  always_ff @(posedge clk_sys) begin
    if (chan_done) begin
      res_q[slot_q] <= kept; // [R05]
    end
  end

  // analog side: channel number and hold strobe
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      chan_sel_q <= 4'h0;
      hold_q <= 1'b0;
    end else begin
      // follow the slot only while a legal conversion runs, never showing channels 12 to 15
      if (go) begin
        chan_sel_q <= {csr_q.group, slot_q}; // [R06]
      end
      hold_q <= st_q == SAC_ST_SAMPLE;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign bus_rdata = rdata_q;
  assign analog_chan_sel = chan_sel_q;
  assign sample_hold = hold_q;
  assign dac_code = dac_q;
  assign conv_end_irq = csr_q.flag & csr_q.irq_en; // [R13] [R16]

endmodule // sac_core

// ### sac_core_props.sv
// concurrent checks on the converter control core ports
`timescale 1ns/1ns
module sac_core_props
  import sac_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire sac_bus_req_t bus_req,
  input wire logic [7:0] bus_rdata,
  input wire logic conv_module_stop_bit,
  input wire logic [3:0] analog_chan_sel,
  input wire logic sample_hold,
  input wire logic [9:0] dac_code,
  input wire logic conv_end_irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // a read that the block takes; stopped reads are ignored
  wire rd_ok = bus_req.rd && !conv_module_stop_bit;
  // sampling is the 26 cycles left over after ten bit steps
  sequence s_sample;
    ##25 sample_hold ##1 !sample_hold;
  endsequence
  // the first trial code tries the top bit alone
  sequence s_first_trial;
    ##[0:1] (dac_code == 10'h200);
  endsequence
  chk_sample_len: assert property ($rose(sample_hold) |-> s_sample ##0 s_first_trial)
    else $error("sample phase or first trial wrong");
  chk_bit_step: assert property (!sample_hold && $changed(dac_code) |=> $stable(dac_code) [*8])
    else $error("trial code changed too soon");
  chk_chan_legal: assert property (analog_chan_sel <= 4'hb)
    else $error("channel select out of range");
  chk_chan_steady: assert property (sample_hold && $past(sample_hold) |-> $stable(analog_chan_sel))
    else $error("channel moved while sampling");
  chk_low_pad: assert property (rd_ok && bus_req.idx[0] && !bus_req.idx[3] |=> bus_rdata[5:0] == 6'h00)
    else $error("low result bits not zero");
  chk_stop_rdata: assert property (conv_module_stop_bit && bus_req.rd |=> $stable(bus_rdata))
    else $error("read answered while stopped");
  chk_stop_idle: assert property (conv_module_stop_bit [*3] |-> !sample_hold)
    else $error("sampling while stopped");
  chk_irq_fall: assert property ($fell(conv_end_irq) |-> $past(bus_req.wr) || $past(rd_ok && bus_req.xfer))
    else $error("interrupt dropped without cause");
endmodule // sac_core_props

// ### sac_pkg.sv
// package for the converter control: register map, fields, timing, types
package sac_pkg;

  // ------------------------------------------------------------
  // byte register indexes on the 8-bit internal path
  // ------------------------------------------------------------
  localparam logic [3:0] SAC_IDX_RES_A_HI = 4'h0;
  localparam logic [3:0] SAC_IDX_RES_A_LO = 4'h1;
  localparam logic [3:0] SAC_IDX_RES_D_LO = 4'h7;
  localparam logic [3:0] SAC_IDX_CSR = 4'h8;
  localparam logic [3:0] SAC_IDX_CTRL = 4'h9;

  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int SAC_CSR_FLAG_BIT = 7;
  localparam int SAC_CSR_IE_BIT = 6;
  localparam int SAC_CSR_START_BIT = 5;
  localparam int SAC_CSR_SCAN_BIT = 4;
  localparam int SAC_CTRL_TMR_EN_BIT = 0;
  localparam int SAC_CTRL_EXT_EN_BIT = 1;
  localparam logic [7:0] SAC_CSR_RESET = 8'h00;
  localparam logic [7:0] SAC_CTRL_RESET = 8'h00;
  localparam logic [1:0] SAC_GROUP_BAD = 2'h3;
  localparam int SAC_RES_W = 10;
  localparam logic [5:0] SAC_RES_PAD = 6'h00;

  // ------------------------------------------------------------
  // timing: per-channel time at the reference clock, in cycles
  // ------------------------------------------------------------
  localparam int SAC_CONV_TIME_PS = 13300000;
  localparam int SAC_REF_CLK_MHZ = 20;
  localparam int SAC_CONV_CYC = SAC_CONV_TIME_PS * SAC_REF_CLK_MHZ / 1000000;
  localparam int SAC_BIT_CYC = 24;
  localparam int SAC_SAMPLE_CYC = SAC_CONV_CYC - SAC_RES_W * SAC_BIT_CYC;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic flag;
    logic irq_en;
    logic start;
    logic scan;
    logic [1:0] group;
    logic [1:0] chan;
  } sac_csr_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic xfer;
    logic [3:0] idx;
    logic [7:0] wdata;
  } sac_bus_req_t;

  typedef enum logic [1:0] {
    SAC_ST_IDLE,
    SAC_ST_SAMPLE,
    SAC_ST_BITS
  } sac_state_t;

endpackage

// ### tb_sac_core.sv
// self-checking bench for the converter control core
`timescale 1ns/1ns
module tb_sac_core;
  import sac_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic stp = 1'b0;
  logic tmr = 1'b0;
  logic ext = 1'b1;
  logic pend = 1'b0;
  sac_bus_req_t req = '0;
  logic [7:0] bus_rdata;
  logic comp_above;
  logic [3:0] chan;
  logic sh;
  logic [9:0] dac;
  logic irq;
  logic [11:0][9:0] lvl;
  logic [31:0] rng = 32'h0000_accb;
  logic [7:0] exp_q[$];
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  sac_core uut (.clk_sys, .arst_n, .bus_req(req), .bus_rdata, .conv_module_stop_bit(stp),
    .timer_pulse_unit_trig(tmr), .ext_conv_trigger(ext), .comp_above,
    .analog_chan_sel(chan), .sample_hold(sh), .dac_code(dac), .conv_end_irq(irq));
  sac_afe_model afe (.clk_sys, .level(lvl), .analog_chan_sel(chan), .sample_hold(sh),
    .dac_code(dac), .comp_above);
  always #2 clk_sys = ~clk_sys;
  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic end_of_test();
    if (miscompares == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // one request held for the edge that takes it; d is the write data or the read expectation
  task automatic bus(logic w, logic x, logic [3:0] i, logic [7:0] d);
    if (!w && !stp)
      exp_q.push_back(d);
    req <= '{rd: !w, wr: w, xfer: x, idx: i, wdata: w ? d : 8'h00};
    @(posedge clk_sys);
  endtask
  task automatic wt(int n);
    req <= '0;
    repeat (n) @(posedge clk_sys);
  endtask
  // single conversion from software, timer or pin, then flag clearing
  task automatic conv(int m, logic [1:0] g, logic [1:0] c);
    logic [7:0] f;
    logic [9:0] v;
    f = {1'b0, m[0], 2'b00, g, c};
    v = lvl[{g, c}];
    bus(1, 0, 4'h9, m == 3 ? 8'h01 : m == 4 ? 8'h02 : 8'h00);
    bus(1, 0, 4'h8, m < 3 ? f | 8'h20 : f);
    tmr <= m == 3;
    ext <= m != 4;
    wt(1);
    tmr <= 1'b0;
    ext <= 1'b1;
    wt(280);
    chk("irq", m[0], irq);
    bus(1, 0, 4'h8, f);
    bus(0, 0, 4'h8, f | 8'h80);
    bus(1, 0, 4'h8, f);
    bus(0, 0, 4'h8, f);
    bus(0, 0, {1'b0, c, 1'b0}, v[9:2]);
    bus(0, 0, {1'b0, c, 1'b1}, {v[1:0], 6'h00});
    wt(1);
    chk("irq", 0, irq);
  endtask
  // compare each read answer with the oldest noted expectation
  always @(negedge clk_sys) begin
    if (pend)
      chk("bus_rdata", exp_q.pop_front(), bus_rdata);
    pend = req.rd && !stp;
  end
  // hang guard, well above the few thousand cycles needed
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
  end
  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    for (int i = 0; i < 12; i++) begin
      rng = xs(rng);
      lvl[i] = rng[9:0];
    end
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    bus(0, 0, 4'h8, SAC_CSR_RESET);
    bus(0, 0, 4'h9, SAC_CTRL_RESET);
    bus(0, 0, 4'(10 + rng % 6), 8'h00);
    for (int m = 0; m < 5; m++) begin
      rng = xs(rng);
      conv(m, 2'(m % 3), rng[1:0]);
    end
    // scan group 1 over four inputs, then a transfer read clears the flag
    bus(1, 0, 4'h9, 8'h00);
    bus(1, 0, 4'h8, 8'h77);
    wt(1100);
    chk("irq", 1, irq);
    bus(0, 0, 4'h8, 8'hf7);
    bus(0, 1, 4'h0, lvl[4][9:2]);
    bus(0, 0, 4'h8, 8'h77);
    bus(1, 0, 4'h8, 8'h17);
    for (int k = 0; k < 4; k++) begin
      bus(0, 0, 4'(2 * k), lvl[4 + k][9:2]);
      bus(0, 0, 4'(2 * k + 1), {lvl[4 + k][1:0], 6'h00});
    end
    // prohibited group never starts
    bus(1, 0, 4'h8, 8'h2e);
    wt(3);
    bus(0, 0, 4'h8, 8'h0e);
    // module stop aborts a running conversion and drops the start bit
    bus(1, 0, 4'h8, 8'h23);
    wt(100);
    stp <= 1'b1;
    wt(4);
    bus(0, 0, 4'h8, 8'h00);
    stp <= 1'b0;
    wt(1);
    bus(0, 0, 4'h8, 8'h03);
    wt(2);
    end_of_test();
  end
endmodule // tb_sac_core
bind sac_core sac_core_props props_i (.clk_sys, .arst_n, .bus_req, .bus_rdata,
  .conv_module_stop_bit, .analog_chan_sel, .sample_hold, .dac_code, .conv_end_irq);
